// *** core/lxc_params.svh ***
// Constants for the literal, XOR and configuration-load execution block
// What this block does
// - Load-literal puts its 8-bit immediate into the accumulator; flags stay unchanged.
// - Configuration-load copies the whole accumulator into the timer configuration register.
// - Direction-load copies the accumulator into direction register 6 or 7; no flags.
// - XOR-literal XORs accumulator with immediate, writes accumulator, updates zero flag.
// - XOR-file XORs accumulator with file register 0 to 31, updates zero flag.
// - XOR-file destination bit 0 writes accumulator, bit 1 writes the file register.
`ifndef LXC_PARAMS_SVH
`define LXC_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses, low eight address bits)
`define LXC_OFF_INSTR     8'h00
`define LXC_OFF_ACC       8'h04
`define LXC_OFF_CFG       8'h08
`define LXC_OFF_DIR6      8'h0c
`define LXC_OFF_DIR7      8'h10
`define LXC_OFF_STATUS    8'h14
`define LXC_OFF_FILE_BASE 8'h80

// ==========================================================================
// Status fields
`define LXC_ST_ZERO       0
`define LXC_ST_BUSY       1
`define LXC_ST_ILLEGAL    2

// ==========================================================================
// Reset values
`define LXC_RST_ACC       8'h00
`define LXC_RST_CFG       8'hff
`define LXC_RST_DIR       8'hff
`define LXC_RST_INSTR     12'h000

// ==========================================================================
// Instruction encoding
`define LXC_ENC_LOAD_HI   4'hc
`define LXC_ENC_XORL_HI   4'hf
`define LXC_ENC_XORF_HI   6'h06
`define LXC_ENC_NOP       12'h000
`define LXC_ENC_CFG       12'h002
`define LXC_ENC_DIR_HI    9'h000
`define LXC_DIR_SEL_A     3'h6
`define LXC_DIR_SEL_B     3'h7
`define LXC_DEST_BIT      5

// ==========================================================================
// Timing: clock periods per instruction cycle and the last phase index
`define LXC_OSC_PER_INSTR 4
`define LXC_Q_LAST        2'((`LXC_OSC_PER_INSTR) - 1)

`endif

// *** core/lxc_pkg.sv ***
// Types and the instruction decode function of the execution block
`include "lxc_params.svh"

package lxc_pkg;

  typedef enum logic [2:0] {
    LXC_OP_NOP  = 3'b000,
    LXC_OP_LOAD = 3'b001,
    LXC_OP_CFG  = 3'b010,
    LXC_OP_DIR  = 3'b011,
    LXC_OP_XORL = 3'b100,
    LXC_OP_XORF = 3'b101,
    LXC_OP_BAD  = 3'b110
  } lxc_op_t;

  typedef enum logic {
    LXC_ST_IDLE = 1'b0,
    LXC_ST_RUN  = 1'b1
  } lxc_state_t;

  // ========================================================================
  // Decode
  function automatic lxc_op_t lxc_decode(input logic [11:0] instr);
    lxc_op_t op;
    op = LXC_OP_BAD;
    if (instr[11:8] == `LXC_ENC_LOAD_HI) begin
      op = LXC_OP_LOAD;
    end else if (instr[11:8] == `LXC_ENC_XORL_HI) begin
      op = LXC_OP_XORL;
    end else if (instr[11:6] == `LXC_ENC_XORF_HI) begin
      op = LXC_OP_XORF;
    end else if (instr == `LXC_ENC_NOP) begin
      op = LXC_OP_NOP;
    end else if (instr == `LXC_ENC_CFG) begin
      op = LXC_OP_CFG;
    end else if (instr[11:3] == `LXC_ENC_DIR_HI &&
                 (instr[2:0] == `LXC_DIR_SEL_A || instr[2:0] == `LXC_DIR_SEL_B)) begin
      op = LXC_OP_DIR;
    end
    return op;
  endfunction

endpackage

// *** core/lxc_file_regs.sv ***
// Thirty-two byte file register array with one write and two read ports
`timescale 1ns/1ps

module lxc_file_regs #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // Read ports
  input  wire logic [AW-1:0] rd_addr_a,
  output logic      [7:0]    rd_data_a,
  input  wire logic [AW-1:0] rd_addr_b,
  output logic      [7:0]    rd_data_b
);

  logic [7:0] mem [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_cell
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mem[gi] <= 8'h00;
        end else if (wr_en && wr_addr == AW'(gi)) begin
          mem[gi] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

endmodule

// *** core/lxc_alu.sv ***
// Result and flag logic for one instruction
`timescale 1ns/1ps
`include "lxc_params.svh"

module lxc_alu (
  // Operands
  input  wire logic [11:0] instr,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  file_val,
  // Results
  output lxc_pkg::lxc_op_t op,
  output logic      [7:0]  result,
  output logic             zero,
  output logic             to_file
);

  wire logic [7:0] lit;
  wire logic [7:0] xor_lit;
  wire logic [7:0] xor_file;

  assign op       = lxc_pkg::lxc_decode(instr);
  assign lit      = instr[7:0];
  assign xor_lit  = acc ^ lit;
  assign xor_file = acc ^ file_val;
  assign result   = (op == lxc_pkg::LXC_OP_LOAD) ? lit :
                    (op == lxc_pkg::LXC_OP_XORL) ? xor_lit :
                    (op == lxc_pkg::LXC_OP_XORF) ? xor_file : acc;
  assign zero     = (result == 8'h00);
  assign to_file  = (op == lxc_pkg::LXC_OP_XORF) && instr[`LXC_DEST_BIT];

endmodule

// *** core/lxc_exec.sv ***
// Top of the execution block: AHB-Lite register slave and instruction sequencer
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "lxc_params.svh"

module lxc_exec (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Register contents seen by the rest of the core
  output logic      [7:0]  acc_out,
  output logic      [7:0]  cfg_out,
  output logic      [7:0]  dir6_out,
  output logic      [7:0]  dir7_out,
  output logic             zero_out
);

  // ========================================================================
  // Bus address and data phase
  logic        dp_valid;
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic        dp_mapped;

  wire logic   ap_take;
  wire logic   commit_wr;
  wire logic   stall;

  // Upper address bits beyond the block's window make the access unmapped
  assign ap_take = hsel && htrans[1] && hready;

  // Data-phase registers freeze while hready is low, so a stalled write keeps its target
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      dp_mapped <= 1'b0;
    end else if (hready) begin
      dp_valid  <= ap_take;
      dp_write  <= hwrite;
      dp_addr   <= haddr[7:0];
      dp_mapped <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
    end
  end

  // ========================================================================
  // Sequencer state
  lxc_pkg::lxc_state_t state;
  lxc_pkg::lxc_state_t next_state;
  logic [1:0]  qphase;
  logic [1:0]  next_qphase;
  logic [11:0] instr;
  logic [7:0]  acc;
  logic [7:0]  cfg;
  logic [7:0]  dir6;
  logic [7:0]  dir7;
  logic        zero;
  logic        illegal;

  wire logic   busy;
  wire logic   exec_now;

  assign busy     = (state == lxc_pkg::LXC_ST_RUN);
  assign exec_now = busy && (qphase == `LXC_Q_LAST);

  // Writes wait while an instruction is in flight, so bus and execution never collide
  assign stall     = dp_valid && dp_write && busy;
  assign hreadyout = !stall;
  assign hresp     = 1'b0;
  assign commit_wr = dp_valid && dp_write && !busy && dp_mapped;

  // ========================================================================
  // Register select, shared by the write decode and the read mux
  // An unmapped or misaligned access selects nothing: reads give 0, writes vanish
  wire logic   sel_instr;
  wire logic   sel_acc;
  wire logic   sel_cfg;
  wire logic   sel_dir6;
  wire logic   sel_dir7;
  wire logic   sel_status;
  wire logic   sel_file;

  assign sel_instr  = dp_mapped && (dp_addr == `LXC_OFF_INSTR);
  assign sel_acc    = dp_mapped && (dp_addr == `LXC_OFF_ACC);
  assign sel_cfg    = dp_mapped && (dp_addr == `LXC_OFF_CFG);
  assign sel_dir6   = dp_mapped && (dp_addr == `LXC_OFF_DIR6);
  assign sel_dir7   = dp_mapped && (dp_addr == `LXC_OFF_DIR7);
  assign sel_status = dp_mapped && (dp_addr == `LXC_OFF_STATUS);
  assign sel_file   = dp_mapped && dp_addr[7];

  // ========================================================================
  // Write decode
  wire logic   wr_instr;
  wire logic   wr_acc;
  wire logic   wr_status;
  wire logic   wr_file;
  wire lxc_pkg::lxc_op_t issue_op;

  assign wr_instr  = commit_wr && sel_instr;
  assign wr_acc    = commit_wr && sel_acc;
  assign wr_status = commit_wr && sel_status;
  assign wr_file   = commit_wr && sel_file;
  assign issue_op  = lxc_pkg::lxc_decode(hwdata[11:0]);

  // ========================================================================
  // Execution datapath
  lxc_pkg::lxc_op_t op;
  logic [7:0]  result;
  logic        res_zero;
  logic        to_file;
  logic [7:0]  file_a;
  logic [7:0]  file_b;

  lxc_alu u_alu (
    .instr    (instr),
    .acc      (acc),
    .file_val (file_a),
    .op       (op),
    .result   (result),
    .zero     (res_zero),
    .to_file  (to_file)
  );

  wire logic       fw_en;
  wire logic [4:0] fw_addr;
  wire logic [7:0] fw_data;

  // One write port serves bus and execution; they never meet because writes stall
  assign fw_en   = (exec_now && to_file) || wr_file;
  assign fw_addr = exec_now ? instr[4:0] : dp_addr[6:2];
  assign fw_data = exec_now ? result : hwdata[7:0];

  // Two read ports: execution reads its operand while the bus reads another cell
  lxc_file_regs #(
    .DEPTH (32),
    .AW    (5)
  ) u_file (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .wr_en     (fw_en),
    .wr_addr   (fw_addr),
    .wr_data   (fw_data),
    .rd_addr_a (instr[4:0]),
    .rd_data_a (file_a),
    .rd_addr_b (dp_addr[6:2]),
    .rd_data_b (file_b)
  );

  // ========================================================================
  // Next-state selection
  // True for the two XOR forms, the only ones that move the zero flag
  function automatic logic is_xor(input lxc_pkg::lxc_op_t o);
    return (o == lxc_pkg::LXC_OP_XORL) || (o == lxc_pkg::LXC_OP_XORF);
  endfunction

  wire logic acc_from_exec;
  wire logic zero_upd;
  wire logic dir_hit_a;
  wire logic exec_cfg;
  wire logic exec_dir;
  wire logic issue_bad;
  wire logic clear_bad;

  assign acc_from_exec = exec_now && !to_file &&
                         (op == lxc_pkg::LXC_OP_LOAD || is_xor(op));
  // Only the two XOR forms touch the zero flag; loads leave it alone
  assign zero_upd      = exec_now && is_xor(op);
  assign dir_hit_a     = (instr[2:0] == `LXC_DIR_SEL_A);
  // Moves copy the accumulator as it stood before this instruction
  assign exec_cfg      = exec_now && (op == lxc_pkg::LXC_OP_CFG);
  assign exec_dir      = exec_now && (op == lxc_pkg::LXC_OP_DIR);
  // An unknown code is flagged at issue, then runs its four cycles as a no-op
  assign issue_bad     = wr_instr && (issue_op == lxc_pkg::LXC_OP_BAD);
  assign clear_bad     = wr_status && hwdata[`LXC_ST_ILLEGAL];

  // The phase counter only runs while busy and is parked at zero when idle
  always_comb begin
    next_state  = state;
    next_qphase = qphase;
    unique case (state)
      lxc_pkg::LXC_ST_IDLE: begin
        next_qphase = 2'd0;
        if (wr_instr) begin
          next_state = lxc_pkg::LXC_ST_RUN;
        end
      end
      lxc_pkg::LXC_ST_RUN: begin
        next_qphase = qphase + 2'd1;
        if (exec_now) begin
          next_state  = lxc_pkg::LXC_ST_IDLE;
          next_qphase = 2'd0;
        end
      end
    endcase
  end

  // ========================================================================
  // Sequencer and architectural registers
  // Bus writes stall while busy, so bus and execution never write one register together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state  <= lxc_pkg::LXC_ST_IDLE;
      qphase <= 2'd0;
    end else begin
      state  <= next_state;
      qphase <= next_qphase;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr <= `LXC_RST_INSTR;
    end else if (wr_instr) begin
      instr <= hwdata[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= `LXC_RST_ACC;
    end else if (acc_from_exec) begin
      acc <= result;
    end else if (wr_acc) begin
      acc <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= `LXC_RST_CFG;
    end else if (exec_cfg) begin
      cfg <= acc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir6 <= `LXC_RST_DIR;
      dir7 <= `LXC_RST_DIR;
    end else if (exec_dir) begin
      if (dir_hit_a) begin
        dir6 <= acc;
      end else begin
        dir7 <= acc;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero <= 1'b0;
    end else if (zero_upd) begin
      zero <= res_zero;
    end
  end

  // Sticky flag for an unknown code; a new bad issue beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      illegal <= 1'b0;
    end else if (issue_bad) begin
      illegal <= 1'b1;
    end else if (clear_bad) begin
      illegal <= 1'b0;
    end
  end

  // ========================================================================
  // Read mux over stored state, taken in the data phase
  // Reads never stall, so a poll of the busy bit answers in one data phase
  wire logic [7:0] status_val;
  wire logic [31:0] rd_val;

  assign status_val[`LXC_ST_ZERO]    = zero;
  assign status_val[`LXC_ST_BUSY]    = busy;
  assign status_val[`LXC_ST_ILLEGAL] = illegal;
  assign status_val[7:3]             = 5'h00;
  assign rd_val =
    sel_file   ? {24'h000000, file_b} :
    sel_instr  ? {20'h00000, instr} :
    sel_acc    ? {24'h000000, acc} :
    sel_cfg    ? {24'h000000, cfg} :
    sel_dir6   ? {24'h000000, dir6} :
    sel_dir7   ? {24'h000000, dir7} :
    sel_status ? {24'h000000, status_val} : 32'h00000000;

  assign hrdata   = (dp_valid && !dp_write) ? rd_val : 32'h00000000;
  assign acc_out  = acc;
  assign cfg_out  = cfg;
  assign dir6_out = dir6;
  assign dir7_out = dir7;
  assign zero_out = zero;

endmodule

// *** testbench/lxc_exec_checker.sv ***
// Port assertions for the execution block
`timescale 1ns/1ps

module lxc_exec_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hresp,
  // Core side
  input wire logic [7:0]  acc_out,
  input wire logic [7:0]  cfg_out,
  input wire logic [7:0]  dir6_out,
  input wire logic [7:0]  dir7_out,
  input wire logic        zero_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       wr_ph;
  logic [7:0] k_q;
  logic [7:0] acc_q;
  // ========================================================================
  // Instruction commit: data phase of a write to the instruction word
  wire        cmt   = wr_ph && hready;
  wire [11:0] d     = hwdata[11:0];
  wire        ld    = cmt && d[11:8] == 4'hc;
  wire        xl    = cmt && d[11:8] == 4'hf;
  wire        xf0   = cmt && d[11:5] == 7'h0c;
  wire        xf1   = cmt && d[11:5] == 7'h0d;
  wire        quiet = ld || (cmt && (d == 12'h002 || d == 12'h006 || d == 12'h007));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
    end else if (hready) begin
      wr_ph <= hsel && htrans[1] && hwrite && haddr == 32'h0;
    end
  end

  // Operands captured at commit stay put: the next commit stalls behind this one
  always_ff @(posedge hclk) begin
    if (cmt) begin
      k_q   <= hwdata[7:0];
      acc_q <= acc_out;
    end
  end

  // ========================================================================
  // Assertions
  load_value_a: assert property (ld |-> ##5 acc_out == k_q)
    else $error("accumulator not loaded with literal");
  flag_kept_a: assert property (quiet |=> $stable(zero_out) [*5])
    else $error("zero flag moved on a move instruction");
  cfg_copy_a: assert property (cmt && d == 12'h002 |-> ##5 cfg_out == acc_q)
    else $error("configuration register not loaded");
  dir6_copy_a: assert property (cmt && d == 12'h006 |-> ##5 dir6_out == acc_q)
    else $error("direction register 6 not loaded");
  dir7_copy_a: assert property (cmt && d == 12'h007 |-> ##5 dir7_out == acc_q)
    else $error("direction register 7 not loaded");
  xor_lit_a: assert property (xl |-> ##5 acc_out == (acc_q ^ k_q) && zero_out == (acc_q == k_q))
    else $error("literal xor result or zero flag wrong");
  xor_file_zero_a: assert property (xf0 |-> ##5 zero_out == (acc_out == 8'h00))
    else $error("file xor zero flag does not match accumulator");
  file_dest_a: assert property (xf1 |=> $stable(acc_out) [*5])
    else $error("file destination changed the accumulator");
  issue_gap_a: assert property (cmt |=> !cmt [*3])
    else $error("instructions issued closer than four cycles");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");

  cover property (ld);
  cover property (xf1);
  cover property (wr_ph && !hready);
endmodule

bind lxc_exec lxc_exec_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hresp, .acc_out, .cfg_out, .dir6_out, .dir7_out, .zero_out);

// *** testbench/lxc_fetch_model.sv ***
// Fetch-side bus master model that issues instructions and register accesses
`timescale 1ns/1ps

module lxc_fetch_model (
  // Clock
  input wire logic        hclk,
  // Master requests
  output logic            hsel,
  output logic     [31:0] haddr,
  output logic     [1:0]  htrans,
  output logic            hwrite,
  output logic     [2:0]  hsize,
  output logic     [31:0] hwdata,
  // Slave answer
  input wire logic [31:0] hrdata,
  input wire logic        hready
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Bounded wait so a stuck slave ends the run instead of hanging it
  task automatic wait_rdy(output logic ok);
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    ok = (hready === 1'b1);
  endtask

  // Next instruction is held back until the slave accepts it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    logic ok1;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_rdy(ok1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(ok);
    rd = hrdata;
    ok = ok && ok1;
  endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking testbench for the execution block
`timescale 1ns/1ps

module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  acc_out;
  logic [7:0]  cfg_out;
  logic [7:0]  dir6_out;
  logic [7:0]  dir7_out;
  logic        zero_out;
  int          n_fail;
  int          n_compared;

  lxc_exec dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .acc_out, .cfg_out, .dir6_out,
    .dir7_out, .zero_out);
  lxc_fetch_model m (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hrdata,
    .hready(hreadyout));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ========================================================================
  // Tasks
  task conclude;
    $display("counts: %0d compared, %0d wrong", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic ok;
    m.xfer(w, a, wd, rd, ok);
    if (!ok) begin
      n_fail++;
      conclude();
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  // Issue one instruction and poll the busy bit until it retires
  task exe(input logic [11:0] i);
    logic [31:0] v;
    int          n;
    wr(8'h00, {20'h0, i});
    n = 0;
    do begin
      bus(1'b0, 8'h14, 32'h0, v);
      n++;
    end while (v[1] !== 1'b0 && n < 20);
    if (v[1] !== 1'b0) begin
      n_fail++;
      conclude();
    end
  endtask

  // ========================================================================
  // Tests
  initial begin
    n_fail = 0;
    n_compared = 0;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'hff);
    rd_chk(8'h0c, 32'hff);
    rd_chk(8'h10, 32'hff);
    rd_chk(8'h14, 32'h0);
    $display("test reset done");
    exe(12'hc5a);
    exe(12'hf5a);
    chk({31'h0, zero_out}, 32'h1);
    exe(12'hcff);
    rd_chk(8'h04, 32'hff);
    chk({31'h0, zero_out}, 32'h1);
    exe(12'hc00);
    rd_chk(8'h04, 32'h0);
    exe(12'hc3c);
    exe(12'h002);
    rd_chk(8'h08, 32'h3c);
    wr(8'h08, 32'h0);
    chk({24'h0, cfg_out}, 32'h3c);
    exe(12'hc81);
    exe(12'h006);
    exe(12'hc42);
    exe(12'h007);
    chk({16'h0, dir7_out, dir6_out}, 32'h4281);
    rd_chk(8'h0c, 32'h81);
    chk({31'h0, zero_out}, 32'h1);
    $display("test moves done");
    exe(12'hf0f);
    rd_chk(8'h04, 32'h4d);
    chk({31'h0, zero_out}, 32'h0);
    exe(12'hf4d);
    rd_chk(8'h14, 32'h1);
    wr(8'hfc, 32'ha5);
    wr(8'h80, 32'h3c);
    exe(12'hc0f);
    exe(12'h19f);
    rd_chk(8'h04, 32'haa);
    chk({31'h0, zero_out}, 32'h0);
    rd_chk(8'hfc, 32'ha5);
    exe(12'h1a0);
    rd_chk(8'h80, 32'h96);
    rd_chk(8'h04, 32'haa);
    exe(12'hca5);
    exe(12'h1bf);
    rd_chk(8'hfc, 32'h0);
    chk({31'h0, zero_out}, 32'h1);
    rd_chk(8'h04, 32'ha5);
    $display("test xor done");
    wr(8'h00, 32'hc11);
    rd_chk(8'h14, 32'h3);
    rd_chk(8'h04, 32'ha5);
    exe(12'hc22);
    rd_chk(8'h04, 32'h22);
    exe(12'h123);
    rd_chk(8'h14, 32'h5);
    wr(8'h14, 32'h4);
    rd_chk(8'h14, 32'h1);
    wr(8'h18, 32'hff);
    rd_chk(8'h18, 32'h0);
    rd_chk(8'h04, 32'h22);
    $display("test timing and refusals done");
    rd_chk(8'h00, 32'h123);
    exe(12'h000);
    rd_chk(8'h14, 32'h1);
    wr(8'h04, 32'h5c);
    wr(8'h05, 32'h77);
    wr(8'h0c, 32'h00);
    rd_chk(8'h04, 32'h5c);
    rd_chk(8'h05, 32'h0);
    chk({24'h0, acc_out}, 32'h5c);
    chk({23'h0, hresp, dir6_out}, 32'h81);
    $display("test bus access done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(8'h08, 32'hff);
    rd_chk(8'h80, 32'h0);
    chk({16'h0, acc_out, 7'h0, zero_out}, 32'h0);
    $display("test second reset done");
    conclude();
  end
endmodule
